/* pbdaf_pkg.sv */
// Purpose: Shared constants and carriers for the port B/D override block
// Assumes: One I/O clock, combinational override evaluation
// Notes:   Pin indexes are fixed by the pin assignment of both ports
package pbdaf_pkg;
  localparam int PB_WIDTH       = 8;
  localparam int PD_WIDTH       = 7;
  // Port B pin positions
  localparam int PB_CMP_POS     = 0;
  localparam int PB_CMP_NEG     = 1;
  localparam int PB_T0_CMP_A    = 2;
  localparam int PB_T1_CMP_A    = 3;
  localparam int PB_T1_CMP_B    = 4;
  localparam int PB_SER_DATA    = 5;
  localparam int PB_SER_DOUT    = 6;
  localparam int PB_SER_CLK     = 7;
  // Port D pin positions
  localparam int PD_RX          = 0;
  localparam int PD_TX          = 1;
  localparam int PD_EXT_IRQ0    = 2;
  localparam int PD_EXT_IRQ1    = 3;
  localparam int PD_CNT_CLK_A   = 4;
  localparam int PD_CNT_CLK_B   = 5;
  localparam int PD_CAPTURE     = 6;
  // Clock-select positions inside a timer control field
  localparam int CLKSEL_BIT1    = 1;
  localparam int CLKSEL_BIT2    = 2;
  // Normal pull-up code {dir, port, global_off}
  localparam logic [2:0] PULLUP_CODE = 3'h2;
  // Overrides of one pin
  typedef struct packed {
    logic pullup_ovr_en;
    logic pullup_ovr_val;
    logic drive_ovr_en;
    logic drive_ovr_val;
    logic outval_ovr_en;
    logic outval_ovr_val;
    logic toggle_ovr_en;
    logic inen_ovr_en;
    logic inen_ovr_val;
  } pbdaf_ovr_t;
  // Resolved pad control of one pin
  typedef struct packed {
    logic pull_en;
    logic out_en;
    logic out_val;
    logic in_en;
  } pbdaf_pad_t;
endpackage

/* pbdaf_pin.sv */
// Purpose: Resolve one pin's pad controls from port bits and overrides
// Assumes: Purely combinational, no state
// Notes:   Shared by all fifteen pins of ports B and D
`timescale 1ns/1ps
module pbdaf_pin (
  // Normal port controls
  input  wire logic               dir_bit,
  input  wire logic               port_bit,
  input  wire logic               global_pullup_off,
  input  wire logic               sleep_clamp,
  // Alternate-function overrides
  input  wire pbdaf_pkg::pbdaf_ovr_t ovr,
  // Resolved pad
  output      pbdaf_pkg::pbdaf_pad_t pad
);
  logic port_eff;
  // Toggle inverts the port bit before it meets the output mux
  always_comb begin
    port_eff    = port_bit ^ ovr.toggle_ovr_en;
    pad.pull_en = ovr.pullup_ovr_en ? ovr.pullup_ovr_val
                : ({dir_bit, port_bit, global_pullup_off} == pbdaf_pkg::PULLUP_CODE);
    pad.out_en  = ovr.drive_ovr_en ? ovr.drive_ovr_val : dir_bit;
    pad.out_val = pad.out_en & (ovr.outval_ovr_en ? ovr.outval_ovr_val : port_eff);
    pad.in_en   = ovr.inen_ovr_en ? ovr.inen_ovr_val : ~sleep_clamp;
  end
endmodule

/* pbdaf_top.sv */
// Purpose: Alternate-function override logic for ports B and D
// Assumes: Peripherals present their override requests on plain ports
// Notes:   Output value reads zero whenever the driver is off
// Notes on behaviour
// - Pull-up follows override, else dir/port/off=010
// - Driver enable follows override, else direction bit
// - Value override replaces port bit; toggle inverts
// - Input enable override beats sleep clamp
// - Three-wire drives data out on B6 when output
// - B6 input keeps pull-up from port bit
// - Two-wire clock B7 drives low only
// - Two-wire data B5 drives low only
// - B7 input alive if start-irq or pin-change
// - Each B pin wakes on mask and enable
// - Timer1 compares reach B3, B4 via value override
// - Timer0 compares reach B2, D5 via value override
// - Capture enable keeps D6 input alive
// - Both upper clock-select bits enable count input
// - External interrupt enables keep D2, D3 alive
// - D2 outputs sync clock or system clock
// - Transmit forces D1 out; receive forces D0 in
// - Transmit/receive pins leave input override inactive
`timescale 1ns/1ps
module pbdaf_top #(
  parameter int PB_N = pbdaf_pkg::PB_WIDTH,
  parameter int PD_N = pbdaf_pkg::PD_WIDTH
) (
  // Clock and reset
  input  wire logic            ref_clk,
  input  wire logic            sys_rst,
  // Port registers and global controls
  input  wire logic [PB_N-1:0] dir_b,
  input  wire logic [PB_N-1:0] port_b,
  input  wire logic [PD_N-1:0] dir_d,
  input  wire logic [PD_N-1:0] port_d,
  input  wire logic            global_pullup_off,
  input  wire logic            sleep_clamp,
  // Serial interface
  input  wire logic            serif_mode_2w,
  input  wire logic            serif_mode_3w,
  input  wire logic            serif_clock_hold,
  input  wire logic            serif_clock_toggle,
  input  wire logic            serif_start_irq_en,
  input  wire logic            serif_data_out,
  input  wire logic            serif_sda_ovr,
  // Pin-change interrupts
  input  wire logic [PB_N-1:0] pin_change_src,
  input  wire logic            pin_change_irq_en,
  // Timer compare outputs
  input  wire logic            tmr1_cmp_a_en,
  input  wire logic            tmr1_cmp_a_out,
  input  wire logic            tmr1_cmp_b_en,
  input  wire logic            tmr1_cmp_b_out,
  input  wire logic            tmr0_cmp_a_en,
  input  wire logic            tmr0_cmp_a_out,
  input  wire logic            tmr0_cmp_b_en,
  input  wire logic            tmr0_cmp_b_out,
  // Timer inputs
  input  wire logic [2:0]      tmr0_control,
  input  wire logic [2:0]      tmr1_control,
  input  wire logic            capture_en,
  // External interrupts
  input  wire logic            ext_irq_zero_en,
  input  wire logic            ext_irq_one_en,
  // Clock outputs and sync clock input on D2
  input  wire logic            usart_sync_clock_en,
  input  wire logic            usart_sync_clock,
  input  wire logic            usart_sync_in_en,
  input  wire logic            sysclk_output_en,
  input  wire logic            sysclk_output,
  // USART
  input  wire logic            tx_en,
  input  wire logic            transmit_level,
  input  wire logic            rx_en,
  // Resolved pads
  output      logic [PB_N-1:0] pb_pullup,
  output      logic [PB_N-1:0] pb_out_en,
  output      logic [PB_N-1:0] pb_out_val,
  output      logic [PB_N-1:0] pb_in_en,
  output      logic [PD_N-1:0] pd_pullup,
  output      logic [PD_N-1:0] pd_out_en,
  output      logic [PD_N-1:0] pd_out_val,
  output      logic [PD_N-1:0] pd_in_en
);
  pbdaf_pkg::pbdaf_ovr_t ovr_b [PB_N];
  pbdaf_pkg::pbdaf_ovr_t ovr_d [PD_N];
  pbdaf_pkg::pbdaf_pad_t pad_b [PB_N];
  pbdaf_pkg::pbdaf_pad_t pad_d [PD_N];
  logic cnt_clk_a_en;
  logic cnt_clk_b_en;

  // Count clock input is selected by the two upper select bits
  function automatic logic ext_clk_sel(input logic [2:0] ctl);
    ext_clk_sel = ctl[pbdaf_pkg::CLKSEL_BIT2] & ctl[pbdaf_pkg::CLKSEL_BIT1];
  endfunction

  // An override with only the input-enable part active
  function automatic pbdaf_pkg::pbdaf_ovr_t inen_only(input logic keep);
    inen_only             = '0;
    inen_only.inen_ovr_en  = keep;
    inen_only.inen_ovr_val = 1'b1;
  endfunction

  // Port B overrides; pins 0/1 are analog, left to software
  always_comb begin
    cnt_clk_a_en = ext_clk_sel(tmr0_control);
    cnt_clk_b_en = ext_clk_sel(tmr1_control);
    for (int i = 0; i < PB_N; i++) begin
      ovr_b[i] = inen_only(pin_change_src[i] & pin_change_irq_en);
    end
    // Serial clock: open-drain in two-wire, start detect keeps it awake
    ovr_b[pbdaf_pkg::PB_SER_CLK].pullup_ovr_en  = serif_mode_2w;
    ovr_b[pbdaf_pkg::PB_SER_CLK].pullup_ovr_val = 1'b0;
    ovr_b[pbdaf_pkg::PB_SER_CLK].drive_ovr_en   = serif_mode_2w;
    ovr_b[pbdaf_pkg::PB_SER_CLK].drive_ovr_val  =
      (serif_clock_hold | port_b[pbdaf_pkg::PB_SER_CLK]) & dir_b[pbdaf_pkg::PB_SER_CLK];
    ovr_b[pbdaf_pkg::PB_SER_CLK].outval_ovr_en  = serif_mode_2w & dir_b[pbdaf_pkg::PB_SER_CLK];
    ovr_b[pbdaf_pkg::PB_SER_CLK].outval_ovr_val = 1'b0;
    ovr_b[pbdaf_pkg::PB_SER_CLK].toggle_ovr_en  = serif_clock_toggle;
    ovr_b[pbdaf_pkg::PB_SER_CLK].inen_ovr_en    =
      (pin_change_src[pbdaf_pkg::PB_SER_CLK] & pin_change_irq_en) | serif_start_irq_en;
    // Three-wire data out; pull-up stays with the normal logic
    ovr_b[pbdaf_pkg::PB_SER_DOUT].outval_ovr_en  = serif_mode_3w;
    ovr_b[pbdaf_pkg::PB_SER_DOUT].outval_ovr_val = serif_data_out;
    // Serial data: two-wire open-drain, three-wire untouched
    ovr_b[pbdaf_pkg::PB_SER_DATA].drive_ovr_en   = serif_mode_2w;
    ovr_b[pbdaf_pkg::PB_SER_DATA].drive_ovr_val  =
      (serif_sda_ovr | port_b[pbdaf_pkg::PB_SER_DATA]) & dir_b[pbdaf_pkg::PB_SER_DATA];
    ovr_b[pbdaf_pkg::PB_SER_DATA].outval_ovr_en  = serif_mode_2w & dir_b[pbdaf_pkg::PB_SER_DATA];
    ovr_b[pbdaf_pkg::PB_SER_DATA].outval_ovr_val = 1'b0;
    ovr_b[pbdaf_pkg::PB_SER_DATA].inen_ovr_en    =
      (pin_change_src[pbdaf_pkg::PB_SER_DATA] & pin_change_irq_en) | serif_start_irq_en;
    // Timer compare outputs need the direction bit set by software
    ovr_b[pbdaf_pkg::PB_T1_CMP_B].outval_ovr_en  = tmr1_cmp_b_en;
    ovr_b[pbdaf_pkg::PB_T1_CMP_B].outval_ovr_val = tmr1_cmp_b_out;
    ovr_b[pbdaf_pkg::PB_T1_CMP_A].outval_ovr_en  = tmr1_cmp_a_en;
    ovr_b[pbdaf_pkg::PB_T1_CMP_A].outval_ovr_val = tmr1_cmp_a_out;
    ovr_b[pbdaf_pkg::PB_T0_CMP_A].outval_ovr_en  = tmr0_cmp_a_en;
    ovr_b[pbdaf_pkg::PB_T0_CMP_A].outval_ovr_val = tmr0_cmp_a_out;
  end

  // Port D overrides
  always_comb begin
    for (int i = 0; i < PD_N; i++) begin
      ovr_d[i] = '0;
    end
    ovr_d[pbdaf_pkg::PD_CAPTURE]   = inen_only(capture_en);
    ovr_d[pbdaf_pkg::PD_CNT_CLK_B] = inen_only(cnt_clk_b_en);
    ovr_d[pbdaf_pkg::PD_CNT_CLK_B].outval_ovr_en  = tmr0_cmp_b_en;
    ovr_d[pbdaf_pkg::PD_CNT_CLK_B].outval_ovr_val = tmr0_cmp_b_out;
    ovr_d[pbdaf_pkg::PD_CNT_CLK_A] = inen_only(cnt_clk_a_en);
    ovr_d[pbdaf_pkg::PD_EXT_IRQ1]  = inen_only(ext_irq_one_en);
    ovr_d[pbdaf_pkg::PD_EXT_IRQ0]  = inen_only(ext_irq_zero_en | usart_sync_in_en);
    // Sync clock takes priority over the system clock output
    ovr_d[pbdaf_pkg::PD_EXT_IRQ0].outval_ovr_en  = usart_sync_clock_en | sysclk_output_en;
    ovr_d[pbdaf_pkg::PD_EXT_IRQ0].outval_ovr_val = usart_sync_clock_en ? usart_sync_clock : sysclk_output;
    // Transmit: forced output, no pull-up; input override stays off
    ovr_d[pbdaf_pkg::PD_TX].pullup_ovr_en  = tx_en;
    ovr_d[pbdaf_pkg::PD_TX].drive_ovr_en   = tx_en;
    ovr_d[pbdaf_pkg::PD_TX].drive_ovr_val  = 1'b1;
    ovr_d[pbdaf_pkg::PD_TX].outval_ovr_en  = tx_en;
    ovr_d[pbdaf_pkg::PD_TX].outval_ovr_val = transmit_level;
    // Receive: forced input, pull-up value as tabled
    ovr_d[pbdaf_pkg::PD_RX].pullup_ovr_en  = rx_en;
    ovr_d[pbdaf_pkg::PD_RX].pullup_ovr_val = port_d[pbdaf_pkg::PD_RX] & global_pullup_off;
    ovr_d[pbdaf_pkg::PD_RX].drive_ovr_en   = rx_en;
  end

  // One resolver per pin, no registers in the path
  for (genvar g = 0; g < PB_N; g++) begin : g_pb
    pbdaf_pin u_pin (
      .dir_bit           (dir_b[g]),
      .port_bit          (port_b[g]),
      .global_pullup_off (global_pullup_off),
      .sleep_clamp       (sleep_clamp),
      .ovr               (ovr_b[g]),
      .pad               (pad_b[g])
    );
    assign pb_pullup[g]  = pad_b[g].pull_en;
    assign pb_out_en[g]  = pad_b[g].out_en;
    assign pb_out_val[g] = pad_b[g].out_val;
    assign pb_in_en[g]   = pad_b[g].in_en;
  end
  for (genvar g = 0; g < PD_N; g++) begin : g_pd
    pbdaf_pin u_pin (
      .dir_bit           (dir_d[g]),
      .port_bit          (port_d[g]),
      .global_pullup_off (global_pullup_off),
      .sleep_clamp       (sleep_clamp),
      .ovr               (ovr_d[g]),
      .pad               (pad_d[g])
    );
    assign pd_pullup[g]  = pad_d[g].pull_en;
    assign pd_out_en[g]  = pad_d[g].out_en;
    assign pd_out_val[g] = pad_d[g].out_val;
    assign pd_in_en[g]   = pad_d[g].in_en;
  end

  // Checks, clocked only to sample the combinational outputs
  pullup_norm_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!serif_mode_2w && dir_b[0] == 1'b0) |-> pb_pullup[0] == (port_b[0] & ~global_pullup_off))
    else $error("Normal pull-up wrong on B0");
  clk_open_drain_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    serif_mode_2w |-> (!pb_pullup[7] && !pb_out_val[7]
      && pb_out_en[7] == ((serif_clock_hold | port_b[7]) & dir_b[7])))
    else $error("Two-wire clock not open drain");
  sda_open_drain_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    serif_mode_2w |-> (!pb_out_val[5] && pb_out_en[5] == ((serif_sda_ovr | port_b[5]) & dir_b[5])))
    else $error("Two-wire data not open drain");
  dout_drive_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (serif_mode_3w && !serif_mode_2w && dir_b[6]) |-> (pb_out_en[6] && pb_out_val[6] == serif_data_out))
    else $error("Three-wire data out not driven");
  dout_pullup_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (serif_mode_3w && !dir_b[6] && port_b[6] && !global_pullup_off) |-> pb_pullup[6])
    else $error("B6 pull-up lost in three-wire");
  pin_change_src_wake_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (pin_change_irq_en && pin_change_src[2]) |-> pb_in_en[2])
    else $error("Pin-change input clamped");
  cnt_clk_wake_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (tmr0_control[2:1] == 2'h3) |-> pd_in_en[4])
    else $error("Count clock input clamped");
  tx_force_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    tx_en |-> (pd_out_en[1] && !pd_pullup[1] && pd_out_val[1] == transmit_level))
    else $error("Transmit pin not forced");
  rx_force_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rx_en |-> (!pd_out_en[0] && pd_pullup[0] == (port_d[0] & global_pullup_off)))
    else $error("Receive pin not forced");
  rx_sleep_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    sleep_clamp |-> (!pd_in_en[0] && !pd_in_en[1]))
    else $error("Serial pin input ignores sleep");
  capture_wake_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(capture_en) |-> pd_in_en[6])
    else $error("Capture input clamped");
  drive_norm_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pb_out_en[4] == dir_b[4])
    else $error("B4 driver ignores direction bit");
  clk_dir_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !serif_mode_2w |-> pb_out_en[7] == dir_b[7])
    else $error("B7 driver ignores direction bit");
  value_norm_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (dir_b[4] && !tmr1_cmp_b_en) |-> pb_out_val[4] == port_b[4])
    else $error("B4 value not from port bit");
  toggle_inv_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (serif_mode_3w && !serif_mode_2w && dir_b[7] && serif_clock_toggle) |-> pb_out_val[7] == !port_b[7])
    else $error("Toggle does not invert B7");
  off_value_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !pd_out_en[5] |-> !pd_out_val[5])
    else $error("Value shown with driver off");
  awake_inputs_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !sleep_clamp |-> (&pb_in_en && &pd_in_en))
    else $error("Input clamped while awake");
  sleep_clamp_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (sleep_clamp && !pin_change_irq_en) |-> pb_in_en[4:0] == 5'h00)
    else $error("Sleep clamp ignored on B0-B4");
  dout_input_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (serif_mode_3w && !serif_mode_2w && !dir_b[6]) |-> (!pb_out_en[6] && !pb_out_val[6]))
    else $error("B6 driven while input");
  sck_start_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (serif_mode_3w && serif_start_irq_en) |-> pb_in_en[7])
    else $error("Serial clock input clamped");
  sck_pin_change_src_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (pin_change_irq_en && pin_change_src[7]) |-> pb_in_en[7])
    else $error("B7 pin-change input clamped");
  pin_change_src_all_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pin_change_irq_en |-> (pb_in_en & pin_change_src) == pin_change_src)
    else $error("Masked pin-change input clamped");
  cmp1a_out_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (dir_b[3] && tmr1_cmp_a_en) |-> pb_out_val[3] == tmr1_cmp_a_out)
    else $error("Timer1 compare A missing on B3");
  cmp1b_out_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (dir_b[4] && tmr1_cmp_b_en) |-> pb_out_val[4] == tmr1_cmp_b_out)
    else $error("Timer1 compare B missing on B4");
  cmp0a_out_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (dir_b[2] && tmr0_cmp_a_en) |-> pb_out_val[2] == tmr0_cmp_a_out)
    else $error("Timer0 compare A missing on B2");
  cmp0b_out_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (dir_d[5] && tmr0_cmp_b_en) |-> pd_out_val[5] == tmr0_cmp_b_out)
    else $error("Timer0 compare B missing on D5");
  capture_held_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    capture_en |-> pd_in_en[6])
    else $error("Capture input clamped while enabled");
  cnt_clk_b_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (tmr1_control[2:1] == 2'h3) |-> pd_in_en[5])
    else $error("Second count clock input clamped");
  cnt_clk_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (sleep_clamp && tmr0_control[2:1] != 2'h3) |-> !pd_in_en[4])
    else $error("Unused count clock input kept awake");
  irq_one_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ext_irq_one_en |-> pd_in_en[3])
    else $error("External irq one input clamped");
  irq_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ext_irq_zero_en |-> pd_in_en[2])
    else $error("External irq zero input clamped");
  sync_clk_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (dir_d[2] && usart_sync_clock_en) |-> pd_out_val[2] == usart_sync_clock)
    else $error("Sync clock missing on D2");
  sysclk_out_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (dir_d[2] && !usart_sync_clock_en && sysclk_output_en) |-> pd_out_val[2] == sysclk_output)
    else $error("System clock missing on D2");
  pullup_d0_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !rx_en |-> pd_pullup[0] == (!dir_d[0] && port_d[0] && !global_pullup_off))
    else $error("Normal pull-up wrong on D0");
endmodule

/* pbdaf_pads.sv */
// Purpose: Pin-side model of the pads of one port
// Assumes: Undriven pins without pull-up float
// Notes:   A floating pin shows the inverse of its last level
`timescale 1ns/1ps
module pbdaf_pads #(
  parameter int N = 8
) (
  // Clock
  input  wire logic         ref_clk,
  // Pad controls from the block
  input  wire logic [N-1:0] out_en,
  input  wire logic [N-1:0] out_val,
  input  wire logic [N-1:0] pull_on,
  // Pin levels
  output      logic [N-1:0] level
);
  logic [N-1:0] last_r = '0;
  // Floating pins flip so a settled unknown never passes; analog pins B0/B1 float too
  always_comb level = (out_en & out_val) | (~out_en & pull_on) | (~out_en & ~pull_on & ~last_r);
  // Remember the level for the next float
  always_ff @(posedge ref_clk) last_r <= level;
endmodule

/* port_bd_alt_function_override_tb.sv */
// Purpose: Self-checking bench for the port B/D override block
// Assumes: Outputs are combinational, so they are sampled at the falling edge
// Notes:   Random inputs from a fixed-seed shift register, checked against a bench model
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module port_bd_alt_function_override_tb;
  localparam logic lo = 1'h0;
  localparam logic hi = 1'h1;
  logic ref_clk = 1'h0, sys_rst = 1'h1;
  logic [7:0] dir_b = '0, port_b = '0, pin_change_src = '0, lvl_b, pb_pullup, pb_out_en, pb_out_val, pb_in_en;
  logic [6:0] dir_d = '0, port_d = '0, lvl_d, pd_pullup, pd_out_en, pd_out_val, pd_in_en;
  logic [2:0] tmr0_control = '0, tmr1_control = '0;
  logic global_pullup_off = 1'h0, sleep_clamp = 1'h0, serif_mode_2w = 1'h0, serif_mode_3w = 1'h0;
  logic serif_clock_hold = 1'h0, serif_clock_toggle = 1'h0, serif_start_irq_en = 1'h0, serif_data_out = 1'h0;
  logic serif_sda_ovr = 1'h0, pin_change_irq_en = 1'h0, capture_en = 1'h0, ext_irq_zero_en = 1'h0;
  logic tmr1_cmp_a_en = 1'h0, tmr1_cmp_a_out = 1'h0, tmr1_cmp_b_en = 1'h0, tmr1_cmp_b_out = 1'h0;
  logic tmr0_cmp_a_en = 1'h0, tmr0_cmp_a_out = 1'h0, tmr0_cmp_b_en = 1'h0, tmr0_cmp_b_out = 1'h0;
  logic ext_irq_one_en = 1'h0, usart_sync_clock_en = 1'h0, usart_sync_clock = 1'h0, usart_sync_in_en = 1'h0;
  logic sysclk_output_en = 1'h0, sysclk_output = 1'h0, tx_en = 1'h0, transmit_level = 1'h0, rx_en = 1'h0;
  logic [31:0] seed = 32'h2746, r1, r2, r3;
  int mismatches = 0, checks = 0;

  // Clock at 40 MHz
  always #12.5 ref_clk = ~ref_clk;

  pbdaf_top dut (.*);
  pbdaf_pads #(.N(8)) pads_b (.ref_clk(ref_clk), .out_en(pb_out_en), .out_val(pb_out_val),
    .pull_on(pb_pullup), .level(lvl_b));
  pbdaf_pads #(.N(7)) pads_d (.ref_clk(ref_clk), .out_en(pd_out_en), .out_val(pd_out_val),
    .pull_on(pd_pullup), .level(lvl_d));

  // Shift-register random source
  function automatic logic [31:0] lfsr();
    seed = {seed[30:0], 1'h0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
    return seed;
  endfunction

  // Resolve one pin; raw port bit for the pull-up is safe since toggle only comes with dir set
  function automatic pbdaf_pkg::pbdaf_pad_t res(input logic d, input logic p, input pbdaf_pkg::pbdaf_ovr_t o);
    pbdaf_pkg::pbdaf_pad_t r;
    r.pull_en = o.pullup_ovr_en ? o.pullup_ovr_val : ({d, p, global_pullup_off} == 3'h2);
    r.out_en  = o.drive_ovr_en ? o.drive_ovr_val : d;
    r.out_val = r.out_en & (o.outval_ovr_en ? o.outval_ovr_val : (p ^ o.toggle_ovr_en));
    r.in_en   = o.inen_ovr_en ? o.inen_ovr_val : ~sleep_clamp;
    return r;
  endfunction

  // Override requests of one port B pin
  function automatic pbdaf_pkg::pbdaf_ovr_t ovb(input int i);
    logic pc;
    logic m2;
    pc = pin_change_src[i] & pin_change_irq_en;
    m2 = serif_mode_2w;
    case (i)
      7: return '{m2, lo, m2, (serif_clock_hold | port_b[7]) & dir_b[7], m2 & dir_b[7], lo,
                  serif_clock_toggle, pc | serif_start_irq_en, hi};
      6: return '{lo, lo, lo, lo, serif_mode_3w, serif_data_out, lo, pc, hi};
      5: return '{lo, lo, m2, (serif_sda_ovr | port_b[5]) & dir_b[5], m2 & dir_b[5], lo, lo,
                  pc | serif_start_irq_en, hi};
      4: return '{lo, lo, lo, lo, tmr1_cmp_b_en, tmr1_cmp_b_out, lo, pc, hi};
      3: return '{lo, lo, lo, lo, tmr1_cmp_a_en, tmr1_cmp_a_out, lo, pc, hi};
      2: return '{lo, lo, lo, lo, tmr0_cmp_a_en, tmr0_cmp_a_out, lo, pc, hi};
      default: return '{lo, lo, lo, lo, lo, lo, lo, pc, hi};
    endcase
  endfunction

  // Override requests of one port D pin
  function automatic pbdaf_pkg::pbdaf_ovr_t ovd(input int i);
    case (i)
      6: return '{lo, lo, lo, lo, lo, lo, lo, capture_en, hi};
      5: return '{lo, lo, lo, lo, tmr0_cmp_b_en, tmr0_cmp_b_out, lo, &tmr1_control[2:1], hi};
      4: return '{lo, lo, lo, lo, lo, lo, lo, &tmr0_control[2:1], hi};
      3: return '{lo, lo, lo, lo, lo, lo, lo, ext_irq_one_en, hi};
      2: return '{lo, lo, lo, lo, usart_sync_clock_en | sysclk_output_en,
                  usart_sync_clock_en ? usart_sync_clock : sysclk_output, lo,
                  ext_irq_zero_en | usart_sync_in_en, hi};
      1: return '{tx_en, lo, tx_en, hi, tx_en, transmit_level, lo, lo, lo};
      default: return '{rx_en, port_d[0] & global_pullup_off, rx_en, lo, lo, lo, lo, lo, lo};
    endcase
  endfunction

  // Compare every pad output with the model in the same cycle
  task automatic check_all();
    pbdaf_pkg::pbdaf_pad_t e;
    logic [7:0] xp, xe, xv, xi, lm;
    logic [6:0] dp, de, dv, di, dm;
    @(negedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      e = res(dir_b[i], port_b[i], ovb(i));
      {xp[i], xe[i], xv[i], xi[i]} = e;
      lm[i] = e.out_en | e.pull_en;
    end
    for (int i = 0; i < 7; i++) begin
      e = res(dir_d[i], port_d[i], ovd(i));
      {dp[i], de[i], dv[i], di[i]} = e;
      dm[i] = e.out_en | e.pull_en;
    end
    `CHK(pb_pullup, xp)
    `CHK(pb_out_en, xe)
    `CHK(pb_out_val, xv)
    `CHK(pb_in_en, xi)
    `CHK(pd_pullup, dp)
    `CHK(pd_out_en, de)
    `CHK(pd_out_val, dv)
    `CHK(pd_in_en, di)
    `CHK({lvl_d & dm, lvl_b & lm}, {(dv | ~de) & dm, (xv | ~xe) & lm})
  endtask

  // Closing verdict
  task automatic conclude();
    if (mismatches == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Cut a hang short
  initial begin
    repeat (100000) @(posedge ref_clk);
    mismatches++;
    conclude();
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'h0;
    check_all();
    @(posedge ref_clk);
    tx_en <= 1'h1;
    transmit_level <= 1'h1;
    check_all();
    for (int n = 0; n < 3000; n++) begin
      @(posedge ref_clk);
      r1 = lfsr();
      r2 = lfsr();
      r3 = lfsr();
      r1[5] = r1[5] & ~r2[1]; // B5 stays input in three-wire mode
      if (r3[10]) r1 = r1 & 32'hFFFFFCFC; // Analog B0/B1: input, port bit low so no pull-up
      {sleep_clamp, global_pullup_off, port_d, dir_d, port_b, dir_b} <= r1;
      serif_mode_2w <= r2[0] & ~r2[1]; // Modes never both on
      serif_mode_3w <= r2[1]; // B5 left as plain port in three-wire mode
      serif_clock_toggle <= r3[9] & r1[7]; // Toggle only with B7 driven
      {serif_sda_ovr, serif_data_out, serif_start_irq_en, serif_clock_hold} <= r2[6:3];
      {pin_change_irq_en, pin_change_src} <= r2[15:7];
      {tmr0_cmp_b_out, tmr0_cmp_b_en, tmr0_cmp_a_out, tmr0_cmp_a_en} <= r2[23:20];
      {tmr1_cmp_b_out, tmr1_cmp_b_en, tmr1_cmp_a_out, tmr1_cmp_a_en} <= r2[19:16];
      {ext_irq_zero_en, capture_en, tmr1_control, tmr0_control} <= r2[31:24];
      {rx_en, transmit_level, tx_en, sysclk_output, sysclk_output_en} <= r3[8:4];
      {usart_sync_in_en, usart_sync_clock, usart_sync_clock_en, ext_irq_one_en} <= r3[3:0];
      check_all();
    end
    conclude();
  end
endmodule
